// file: common/fspc_pkg.sv
`default_nettype none
package fspc_pkg;
  // -----------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------
  localparam logic [3:0] ADDR_LOW_OFF   = 4'h0;
  localparam logic [3:0] ADDR_HIGH_OFF  = 4'h1;
  localparam logic [3:0] DATA_LOW_OFF   = 4'h2;
  localparam logic [3:0] DATA_HIGH_OFF  = 4'h3;
  localparam logic [3:0] CONTROL_OFF    = 4'h4;
  localparam logic [3:0] UNLOCK_OFF     = 4'h5;
  localparam logic [3:0] IRQ_STAT_OFF   = 4'h6;
  localparam logic [3:0] IRQ_MASK_OFF   = 4'h7;
  // -----------------------------------------------------------
  // control bit positions
  // -----------------------------------------------------------
  localparam int CTL_SPACE_BIT  = 6;
  localparam int CTL_LATCH_BIT  = 5;
  localparam int CTL_ERASE_BIT  = 4;
  localparam int CTL_ERR_BIT    = 3;
  localparam int CTL_EN_BIT     = 2;
  localparam int CTL_WR_BIT     = 1;
  localparam int CTL_RD_BIT     = 0;
  // -----------------------------------------------------------
  // keys, reset values, geometry, timing
  // -----------------------------------------------------------
  localparam logic [7:0]  UNLOCK_KEY1    = 8'h55;
  localparam logic [7:0]  UNLOCK_KEY2    = 8'haa;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  TOP_BIT_ONE    = 8'h80;
  localparam logic [14:0] USER_ID_FIRST  = 15'h0000;
  localparam logic [14:0] USER_ID_LAST   = 15'h0003;
  localparam logic [14:0] DEV_ID_ADDR    = 15'h0006;
  localparam logic [14:0] CFG_WORD_FIRST = 15'h0007;
  localparam logic [14:0] CFG_WORD_LAST  = 15'h0008;
  localparam int          ROW_WORDS      = 32;
  localparam int          NOP_CYCLES     = 2;
  localparam int          CLK_MHZ        = 40;
  localparam int          PROG_TIME_US   = 2;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  // -----------------------------------------------------------
  // types
  // -----------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        erase;
    logic        cfg;
    logic [14:0] addr;
  } fspc_op_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_NOP   = 4'b0010,
    ST_BUSY  = 4'b0100,
    ST_DONE  = 4'b1000
  } fspc_state_t;
endpackage : fspc_pkg
`default_nettype wire

// file: core/fspc_top.sv
// Functional notes
// - word address is low byte plus low seven bits of high byte.
// - space select steers access to config/ID region or program array.
// - with latch-only set a write-start only loads the addressed latch.
// - with latch-only clear a write-start loads the latch then programs only the addressed word from it.
// - erase select makes write-start erase the row and is cleared when done.
// - latch-only is ignored during an erase.
// - error flag is set on any attempt to set write-start while write-start is clear.
// - program enable low inhibits every program and erase.
// - write-start launches a self-timed operation, cleared by hardware only.
// - read-start fetches the word into the data pair in one cycle then clears.
// - unused top bit of address high and control reads one; address and control reset to zero.
// - config space user ids writable, ids and config words read-only, others zero.
// - data pair holds a 14-bit word, upper two bits of high byte read zero.
// - a row has 32 write latches picked by the low five address bits.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`default_nettype none
module fspc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             irq_o,
  output logic             cpu_nop_o,
  output logic             cpu_stall_o,
  output logic             arr_req_o,
  output logic             arr_erase_o,
  output logic             arr_cfg_o,
  output logic      [14:0] arr_addr_o,
  output logic      [13:0] arr_wdata_o,
  input  wire logic [13:0] arr_rdata_i,
  input  wire logic        arr_done_i
);
  // -----------------------------------------------------------
  // registers
  // -----------------------------------------------------------
  logic [7:0]  addr_low_r;
  logic [6:0]  addr_high_r;
  logic [13:0] data_r;
  logic        space_r, latch_r, erase_r, err_r, en_r, wr_r, rd_r;
  logic [1:0]  key_r;
  logic [1:0]  irq_stat_r, irq_mask_r;
  localparam int ROW_WORDS_L = fspc_pkg::ROW_WORDS;
  logic [13:0] latch_mem_r [ROW_WORDS_L];
  fspc_pkg::fspc_state_t state_r;
  logic [7:0]  cnt_r;
  fspc_pkg::fspc_op_t    op_r;
  logic [14:0] word_addr;
  logic        start_ok, wr_attempt, rd_attempt, op_done;

  // config-region read filter
  function automatic logic cfg_readable(input logic [14:0] a);
    cfg_readable = (a <= fspc_pkg::USER_ID_LAST) || (a == fspc_pkg::DEV_ID_ADDR)
                   || ((a >= fspc_pkg::CFG_WORD_FIRST) && (a <= fspc_pkg::CFG_WORD_LAST));
  endfunction

  // config-region write filter
  function automatic logic cfg_writable(input logic [14:0] a);
    cfg_writable = (a <= fspc_pkg::USER_ID_LAST);
  endfunction

  // -----------------------------------------------------------
  // decode
  // -----------------------------------------------------------
  // word address and start qualification
  assign word_addr  = {addr_high_r, addr_low_r};
  assign wr_attempt = reg_wr_i && (reg_addr_i == fspc_pkg::CONTROL_OFF)
                      && reg_wdata_i[fspc_pkg::CTL_WR_BIT] && !wr_r;
  assign rd_attempt = reg_wr_i && (reg_addr_i == fspc_pkg::CONTROL_OFF)
                      && reg_wdata_i[fspc_pkg::CTL_RD_BIT] && !wr_r;
  assign start_ok   = wr_attempt && reg_wdata_i[fspc_pkg::CTL_EN_BIT]
                      && key_r[1];
  assign op_done    = (state_r == fspc_pkg::ST_BUSY) && arr_done_i && (cnt_r == 8'h00);

  // -----------------------------------------------------------
  // unlock sequence tracker
  // -----------------------------------------------------------
  // key_r[0]: 55h seen last; key_r[1]: 55h then aah were the last two writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_r <= 2'b00;
    else if (ce_i && reg_wr_i)
    begin
      key_r[0] <= (reg_addr_i == fspc_pkg::UNLOCK_OFF) && (reg_wdata_i == fspc_pkg::UNLOCK_KEY1);
      key_r[1] <= key_r[0] && (reg_addr_i == fspc_pkg::UNLOCK_OFF)
                  && (reg_wdata_i == fspc_pkg::UNLOCK_KEY2);
    end
  end

  // -----------------------------------------------------------
  // address registers
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_low_r  <= fspc_pkg::BYTE_RESET;
      addr_high_r <= 7'h00;
    end
    else if (ce_i && reg_wr_i)
    begin
      if (reg_addr_i == fspc_pkg::ADDR_LOW_OFF)
        addr_low_r <= reg_wdata_i;
      if (reg_addr_i == fspc_pkg::ADDR_HIGH_OFF)
        addr_high_r <= reg_wdata_i[6:0];
    end
  end

  // -----------------------------------------------------------
  // control register
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      space_r <= 1'b0;
      latch_r <= 1'b0;
      erase_r <= 1'b0;
      en_r    <= 1'b0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      err_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (reg_wr_i && (reg_addr_i == fspc_pkg::CONTROL_OFF) && !wr_r)
      begin
        space_r <= reg_wdata_i[fspc_pkg::CTL_SPACE_BIT];
        latch_r <= reg_wdata_i[fspc_pkg::CTL_LATCH_BIT];
        erase_r <= reg_wdata_i[fspc_pkg::CTL_ERASE_BIT];
        en_r    <= reg_wdata_i[fspc_pkg::CTL_EN_BIT];
        err_r   <= reg_wdata_i[fspc_pkg::CTL_ERR_BIT];
      end
      if (wr_attempt)
        err_r <= 1'b1;
      if (start_ok)
        wr_r <= 1'b1;
      else if (state_r == fspc_pkg::ST_DONE)
      begin
        wr_r <= 1'b0;
        if (op_r.erase)
          erase_r <= 1'b0;
        err_r <= 1'b0;
      end
      rd_r <= rd_attempt && !wr_r;
    end
  end

  // -----------------------------------------------------------
  // data pair and write latches
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_r <= 14'h0000;
    else if (ce_i)
    begin
      if (reg_wr_i && (reg_addr_i == fspc_pkg::DATA_LOW_OFF))
        data_r[7:0] <= reg_wdata_i;
      else if (reg_wr_i && (reg_addr_i == fspc_pkg::DATA_HIGH_OFF))
        data_r[13:8] <= reg_wdata_i[5:0];
      else if (rd_r)
        data_r <= (!space_r || cfg_readable(word_addr)) ? arr_rdata_i
                  : 14'h0000;
    end
  end

  // latch load on every non-erase write-start
  always_ff @(posedge clk_i)
  begin
    if (ce_i && start_ok && !reg_wdata_i[fspc_pkg::CTL_ERASE_BIT])
      latch_mem_r[addr_low_r[4:0]] <= data_r;
  end

  // -----------------------------------------------------------
  // operation sequencer
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= fspc_pkg::ST_IDLE;
      cnt_r   <= 8'h00;
      op_r    <= '0;
    end
    else if (ce_i)
    begin
      unique case (state_r)
        fspc_pkg::ST_IDLE:
          if (start_ok && (reg_wdata_i[fspc_pkg::CTL_ERASE_BIT]
                           || !reg_wdata_i[fspc_pkg::CTL_LATCH_BIT]))
          begin
            state_r  <= fspc_pkg::ST_NOP;
            cnt_r    <= 8'(fspc_pkg::NOP_CYCLES - 1);
            op_r.erase <= reg_wdata_i[fspc_pkg::CTL_ERASE_BIT];
            op_r.cfg   <= reg_wdata_i[fspc_pkg::CTL_SPACE_BIT];
            op_r.addr  <= word_addr;
            op_r.req   <= !reg_wdata_i[fspc_pkg::CTL_SPACE_BIT]
                          || cfg_writable(word_addr);
          end
          else if (start_ok)
            state_r <= fspc_pkg::ST_DONE;
        fspc_pkg::ST_NOP:
          if (cnt_r == 8'h00)
          begin
            state_r <= fspc_pkg::ST_BUSY;
            cnt_r   <= 8'(fspc_pkg::PROG_CYCLES - 1);
          end
          else
            cnt_r <= cnt_r - 8'h01;
        fspc_pkg::ST_BUSY:
          if (op_done || (!op_r.req && cnt_r == 8'h00))
            state_r <= fspc_pkg::ST_DONE;
          else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        fspc_pkg::ST_DONE:
          state_r <= fspc_pkg::ST_IDLE;
        default:
          state_r <= fspc_pkg::ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------
  // array and core handshake outputs
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      arr_req_o   <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_cfg_o   <= 1'b0;
      arr_addr_o  <= 15'h0000;
      arr_wdata_o <= 14'h0000;
      cpu_nop_o   <= 1'b0;
      cpu_stall_o <= 1'b0;
    end
    else if (ce_i)
    begin
      arr_req_o   <= (state_r == fspc_pkg::ST_BUSY) && op_r.req && !op_done;
      arr_erase_o <= op_r.erase;
      arr_cfg_o   <= rd_attempt ? reg_wdata_i[fspc_pkg::CTL_SPACE_BIT] : op_r.cfg;
      arr_addr_o  <= rd_attempt ? word_addr : op_r.addr;
      arr_wdata_o <= latch_mem_r[op_r.addr[4:0]];
      cpu_nop_o   <= (state_r == fspc_pkg::ST_NOP);
      cpu_stall_o <= (state_r == fspc_pkg::ST_BUSY) && !op_done;
    end
  end

  // -----------------------------------------------------------
  // interrupt status: bit0 op done, bit1 refused start
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      irq_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      if (reg_wr_i && (reg_addr_i == fspc_pkg::IRQ_MASK_OFF))
        irq_mask_r <= reg_wdata_i[1:0];
      // set wins over read-clear
      irq_stat_r <= ((reg_rd_i && reg_addr_i == fspc_pkg::IRQ_STAT_OFF) ? 2'b00 : irq_stat_r)
                    | {wr_attempt && !start_ok, state_r == fspc_pkg::ST_DONE};
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // -----------------------------------------------------------
  // read data
  // -----------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i)
    begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i)
        unique case (reg_addr_i)
          fspc_pkg::ADDR_LOW_OFF:  reg_rdata_o <= addr_low_r;
          fspc_pkg::ADDR_HIGH_OFF: reg_rdata_o <= fspc_pkg::TOP_BIT_ONE
                                                  | {1'b0, addr_high_r};
          fspc_pkg::DATA_LOW_OFF:  reg_rdata_o <= data_r[7:0];
          fspc_pkg::DATA_HIGH_OFF: reg_rdata_o <= {2'b00, data_r[13:8]};
          fspc_pkg::CONTROL_OFF:   reg_rdata_o <= {1'b1, space_r, latch_r, erase_r,
                                                   err_r, en_r, wr_r, rd_r};
          fspc_pkg::IRQ_STAT_OFF:  reg_rdata_o <= {6'h00, irq_stat_r};
          fspc_pkg::IRQ_MASK_OFF:  reg_rdata_o <= {6'h00, irq_mask_r};
          default:                 reg_rdata_o <= 8'h00;
        endcase
    end
  end
endmodule // fspc_top
`default_nettype wire

// file: testbench/fspc_flash_model.sv
`default_nettype none
// -----------------------------------------------------------
// flash array stand-in
// -----------------------------------------------------------
module fspc_flash_model #(
  parameter int DELAY = 100
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        arr_req_i,
  input  wire logic [14:0] arr_addr_i,
  input  wire logic        arr_cfg_i,
  output logic      [13:0] arr_rdata_o,
  output logic             arr_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // stored word pattern, one per address and region
  assign arr_rdata_o = arr_addr_i[13:0] ^ (arr_cfg_i ? 14'h2aaa : 14'h1555);
  // self-timed count, done only while request stays
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !arr_req_i)
      cnt <= 0;
    else if (cnt != DELAY)
      cnt <= cnt + 1;
  end
  assign arr_done_o = arr_req_i && cnt == DELAY;
endmodule // fspc_flash_model
`default_nettype wire

// file: testbench/fspc_top_asserts.sv
`default_nettype none
module fspc_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        irq_o,
  input wire logic        cpu_nop_o,
  input wire logic        cpu_stall_o,
  input wire logic        arr_req_o,
  input wire logic        arr_erase_o,
  input wire logic        arr_cfg_o,
  input wire logic [14:0] arr_addr_o,
  input wire logic        arr_done_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       rd_top, rd_dh, st_rd, mk_wr, go_wr;
  logic [3:0] since_go;
  // -----------------------------------------------------------
  // decoded register accesses
  // -----------------------------------------------------------
  assign rd_top = reg_rd_i && (reg_addr_i == fspc_pkg::ADDR_HIGH_OFF
                  || reg_addr_i == fspc_pkg::CONTROL_OFF);
  assign rd_dh = reg_rd_i && reg_addr_i == fspc_pkg::DATA_HIGH_OFF;
  assign st_rd = reg_rd_i && reg_addr_i == fspc_pkg::IRQ_STAT_OFF;
  assign mk_wr = reg_wr_i && reg_addr_i == fspc_pkg::IRQ_MASK_OFF;
  assign go_wr = reg_wr_i && reg_addr_i == fspc_pkg::CONTROL_OFF && reg_wdata_i[1];
  // cycles since last write-start request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      since_go <= 4'hf;
    else if (go_wr)
      since_go <= 4'h0;
    else if (since_go != 4'hf)
      since_go <= since_go + 4'h1;
  end
  // -----------------------------------------------------------
  // properties
  // -----------------------------------------------------------
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read reply");
  top_one_a: assert property ($past(rd_top) |-> reg_rdata_o[7])
    else $error("unused top bit not one");
  data_hi_a: assert property ($past(rd_dh) |-> reg_rdata_o[7:6] == 2'b00)
    else $error("data high upper bits not zero");
  nop_len_a: assert property ($rose(cpu_nop_o) |-> cpu_nop_o[*2] ##1 !cpu_nop_o)
    else $error("forced idle not two cycles");
  req_cause_a: assert property ($rose(arr_req_o) |-> since_go < 4'h6)
    else $error("array request without write-start");
  req_stall_a: assert property ($rose(arr_req_o) && !arr_erase_o |-> ##[0:3] cpu_stall_o)
    else $error("core not stalled during write");
  req_hold_a: assert property (arr_req_o && $past(arr_req_o) |->
    $stable(arr_addr_o) && $stable(arr_erase_o) && $stable(arr_cfg_o))
    else $error("operation info moved while busy");
  done_end_a: assert property (arr_req_o && arr_done_i |-> ##[1:100] !arr_req_o)
    else $error("request kept after completion");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(st_rd) || $past(st_rd, 2) || $past(mk_wr) || $past(mk_wr, 2))
    else $error("interrupt dropped without clear");
  // main scenarios seen
  cover property ($rose(arr_req_o) && arr_erase_o);
  cover property ($fell(cpu_stall_o));
  cover property ($fell(irq_o));
endmodule // fspc_top_asserts
bind fspc_top fspc_top_asserts fspc_top_asserts_inst (.clk_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .cpu_nop_o, .cpu_stall_o,
  .arr_req_o, .arr_erase_o, .arr_cfg_o, .arr_addr_o, .arr_done_i);
`default_nettype wire

// file: testbench/fspc_top_test.sv
`default_nettype none
module fspc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} fspc_row_t;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, req_q = 0, ce = 1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata, q;
  logic        irq, nop, stall, req, ers, cfg, done;
  logic [14:0] aaddr;
  logic [13:0] awd, ard;
  int          bad_count = 0, checked = 0, reqs = 0, nops = 0;
  fspc_row_t   rows [6] = '{'{4'h0, 8'ha5, 8'ha5}, '{4'h1, 8'h7f, 8'hff},
    '{4'h2, 8'h3c, 8'h3c}, '{4'h3, 8'hff, 8'h3f}, '{4'h7, 8'h03, 8'h03},
    '{4'hf, 8'h77, 8'h00}};
  // -----------------------------------------------------------
  // design, array model, clock
  // -----------------------------------------------------------
  fspc_top fspc_top_inst (.clk_i(clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
    .cpu_nop_o(nop), .cpu_stall_o(stall), .arr_req_o(req), .arr_erase_o(ers),
    .arr_cfg_o(cfg), .arr_addr_o(aaddr), .arr_wdata_o(awd), .arr_rdata_i(ard),
    .arr_done_i(done));
  fspc_flash_model fspc_flash_model_inst (.clk_i(clk), .rst_i(rst), .arr_req_i(req),
    .arr_addr_i(aaddr), .arr_cfg_i(cfg), .arr_rdata_o(ard), .arr_done_o(done));
  always #12.5 clk = ~clk;
  // count request starts and forced idle cycles
  always @(posedge clk)
  begin
    req_q <= req;
    if (req && !req_q) reqs++;
    if (nop) nops++;
  end
  // -----------------------------------------------------------
  // bus tasks and checks
  // -----------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
    chk(n, q & m, e);
  endtask
  // key pair then control write
  task automatic start(input logic [7:0] c);
    wreg(fspc_pkg::UNLOCK_OFF, 8'h55);
    wreg(fspc_pkg::UNLOCK_OFF, 8'haa);
    wreg(fspc_pkg::CONTROL_OFF, c);
  endtask
  task automatic wait_req;
    for (int i = 0; i < 10 && !req; i++) @(posedge clk);
    #1;
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 400 && (req || stall); i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // -----------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk("addr_low", fspc_pkg::ADDR_LOW_OFF, 8'hff, 8'h00);
    rchk("addr_high", fspc_pkg::ADDR_HIGH_OFF, 8'hff, 8'h80);
    rchk("control", fspc_pkg::CONTROL_OFF, 8'hf7, 8'h80);
    $display("reset values done");
    foreach (rows[i])
    begin
      wreg(rows[i].a, rows[i].w);
      rchk("register", rows[i].a, 8'hff, rows[i].e);
    end
    $display("register table done");
    wreg(fspc_pkg::CONTROL_OFF, 8'h06);
    settle();
    chk("refused_req", reqs[15:0], 16'h0);
    chk("refused_irq", irq, 1'b1);
    rchk("error_flag", fspc_pkg::CONTROL_OFF, 8'h0a, 8'h08);
    rchk("status", fspc_pkg::IRQ_STAT_OFF, 8'h03, 8'h02);
    rchk("status_clear", fspc_pkg::IRQ_STAT_OFF, 8'h03, 8'h00);
    start(8'h02);
    settle();
    chk("no_enable", reqs[15:0], 16'h0);
    wreg(fspc_pkg::UNLOCK_OFF, 8'h55);
    wreg(fspc_pkg::UNLOCK_OFF, 8'haa);
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h25);
    wreg(fspc_pkg::CONTROL_OFF, 8'h06);
    settle();
    chk("broken_keys", reqs[15:0], 16'h0);
    rchk("status", fspc_pkg::IRQ_STAT_OFF, 8'h03, 8'h02);
    $display("refusal tests done");
    wreg(fspc_pkg::ADDR_HIGH_OFF, 8'h01);
    wreg(fspc_pkg::DATA_LOW_OFF, 8'h34);
    wreg(fspc_pkg::DATA_HIGH_OFF, 8'h12);
    start(8'h06);
    wait_req();
    chk("prog_addr", {1'b0, aaddr}, 16'h0125);
    chk("prog_data", {2'b00, awd}, 16'h1234);
    chk("prog_kind", {ers, cfg}, 2'b00);
    wreg(fspc_pkg::CONTROL_OFF, 8'h04);
    chk("busy_kept", req, 1'b1);
    settle();
    chk("nop_count", nops[15:0], 16'h2);
    rchk("prog_end", fspc_pkg::CONTROL_OFF, 8'h0a, 8'h00);
    rchk("status_done", fspc_pkg::IRQ_STAT_OFF, 8'h03, 8'h01);
    $display("program test done");
    start(8'h36);
    wait_req();
    chk("erase_kind", ers, 1'b1);
    settle();
    rchk("erase_end", fspc_pkg::CONTROL_OFF, 8'h12, 8'h00);
    start(8'h26);
    settle();
    chk("latch_only", reqs[15:0], 16'h2);
    rchk("latch_end", fspc_pkg::CONTROL_OFF, 8'h02, 8'h00);
    $display("erase and latch tests done");
    wreg(fspc_pkg::CONTROL_OFF, 8'h01);
    rchk("read_end", fspc_pkg::CONTROL_OFF, 8'h01, 8'h00);
    rchk("rd_low", fspc_pkg::DATA_LOW_OFF, 8'hff, 8'h70);
    rchk("rd_high", fspc_pkg::DATA_HIGH_OFF, 8'hff, 8'h14);
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h06);
    wreg(fspc_pkg::ADDR_HIGH_OFF, 8'h00);
    wreg(fspc_pkg::CONTROL_OFF, 8'h41);
    rchk("id_low", fspc_pkg::DATA_LOW_OFF, 8'hff, 8'hac);
    rchk("id_high", fspc_pkg::DATA_HIGH_OFF, 8'hff, 8'h2a);
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h05);
    wreg(fspc_pkg::CONTROL_OFF, 8'h41);
    rchk("gap_low", fspc_pkg::DATA_LOW_OFF, 8'hff, 8'h00);
    rchk("gap_high", fspc_pkg::DATA_HIGH_OFF, 8'hff, 8'h00);
    $display("read tests done");
    ce <= 1'b0;
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h02);
    ce <= 1'b1;
    rchk("frozen", fspc_pkg::ADDR_LOW_OFF, 8'hff, 8'h05);
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h02);
    start(8'h46);
    wait_req();
    chk("uid_write", {cfg, aaddr}, 16'h8002);
    settle();
    wreg(fspc_pkg::ADDR_LOW_OFF, 8'h07);
    start(8'h46);
    settle();
    chk("cfg_locked", reqs[15:0], 16'h3);
    $display("enable and config write tests done");
    wrap_up();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule // fspc_top_test
`default_nettype wire
